// ---- rtl/phd_pkg.sv ----
package phd_pkg;

    // Instruction word layout: first halfword in [31:16], second in [15:0]
    localparam int HW_HI_MSB        = 31;
    localparam int HW_HI_LSB        = 16;
    localparam int BASE_FIELD_LSB   = 16;
    localparam int BASE_FIELD_W     = 4;
    localparam int UPDOWN_BIT       = 23;
    localparam int WIDE_OFF_W       = 12;
    localparam int NARROW_OFF_W     = 8;
    localparam int SHIFT_FIELD_LSB  = 4;
    localparam int SHIFT_FIELD_W    = 2;
    localparam int OFFREG_LSB       = 0;
    localparam int OFFREG_W         = 4;
    localparam int SECOND_HI_LSB    = 12;
    localparam int MID_LSB          = 6;

    // Opcode patterns of the first halfword with the base field masked off, or with the up bit masked for literals
    localparam logic [15:0] HW_MASK_BASE   = 16'hFFF0;
    localparam logic [15:0] HW_MASK_U      = 16'hFF7F;
    localparam logic [15:0] OP_DATA_WIDE   = 16'hF890;
    localparam logic [15:0] OP_DATA_NARROW = 16'hF810;
    localparam logic [15:0] OP_DATA_LIT    = 16'hF81F;
    localparam logic [15:0] OP_CODE_WIDE   = 16'hF990;
    localparam logic [15:0] OP_CODE_NARROW = 16'hF910;
    localparam logic [15:0] OP_CODE_LIT    = 16'hF91F;
    localparam logic [3:0]  SECOND_HI_PAT  = 4'hF;
    localparam logic [3:0]  NARROW_SEL_PAT = 4'hC;
    localparam logic [5:0]  REG_MID_PAT    = 6'h00;

    // Register numbers with fixed meaning
    localparam logic [3:0] REG_PC = 4'hF;
    localparam logic [3:0] REG_SP = 4'hD;

    // Low address bits dropped when aligning the program counter
    localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFFFFFC;

    // Decoded preload form
    typedef enum logic [2:0] {
        PHD_FORM_NONE,
        PHD_FORM_DATA_WIDE,
        PHD_FORM_DATA_NARROW,
        PHD_FORM_DATA_LIT,
        PHD_FORM_DATA_REG,
        PHD_FORM_CODE_WIDE,
        PHD_FORM_CODE_NARROW,
        PHD_FORM_CODE_LIT
    } phd_form_t;

    // Issued hint toward the memory system
    typedef struct packed {
        logic        data_prefetch_request;
        logic        code_prefetch_request;
        logic        unpredictable;
        logic [31:0] address;
    } phd_hint_t;

endpackage : phd_pkg

// ---- rtl/phd_addr_calc.sv ----
`timescale 1ns/1ps
// Add or subtract an offset from a base; the hint address wraps mod 2^32
module phd_addr_calc (
    // Operands
    input  wire logic [31:0] i_base,
    input  wire logic [31:0] i_offset,
    input  wire logic        i_add,
    // Result
    output wire logic [31:0] o_address
);
    assign o_address = i_add ? (i_base + i_offset) : (i_base - i_offset);
endmodule : phd_addr_calc

// ---- rtl/phd_preload_hint_decode.sv ----
`timescale 1ns/1ps
// What this block does
// RULE1: Immediate data preload: base plus or minus offset
// RULE2: Data preload issues a data prefetch request
// RULE3: Literal: zero-extend twelve bits, up bit adds
// RULE4: Literal base is program counter aligned down four
// RULE5: Assembler keeps literal offsets within plus/minus 4095
// RULE6: Non-negative literal offset: magnitude, add set
// RULE7: Negative literal offset: magnitude, add cleared
// RULE8: Alternative syntax takes magnitude 0-4095 only
// RULE9: Register form with base all ones is literal
// RULE10: Offset register 13 or 15 is unpredictable
// RULE11: Offset register shifted left by 0 to 3
// RULE12: Register form adds shifted offset to base
// RULE13: Stack pointer allowed as register-form base
// RULE14: Instruction preload issues a code prefetch request
// RULE15: Code wide form adds offset; base ones redirects
// RULE16: Code narrow form subtracts zero-extended eight bits
// RULE17: Program counter base aligned down to four bytes
// RULE18: Failed condition issues nothing; no state change
// RULE19: Hints are optional; results never depend on them
module phd_preload_hint_decode
    import phd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    // Instruction from decode stage
    input  wire logic        i_instr_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_cond_pass,
    input  wire logic [31:0] i_pc,
    // Register file read data
    input  wire logic [31:0] i_base_value,
    input  wire logic [31:0] i_offset_value,
    // Register file read addresses
    output logic [3:0]       o_base_reg_field,
    output logic [3:0]       o_offset_reg_field,
    // Hint to memory system
    output logic             o_data_prefetch_request,
    output logic             o_code_prefetch_request,
    output logic             o_unpredictable,
    output logic [31:0]      o_hint_address
);

    // Field extraction; the second halfword sits in [15:0]
    // Every preload form keeps all ones in the top nibble of that halfword
    wire logic [15:0] first_hw      = i_instr[HW_HI_MSB:HW_HI_LSB];
    wire logic [3:0]  base_reg_field =
        i_instr[BASE_FIELD_LSB +: BASE_FIELD_W];
    wire logic [3:0]  offset_reg_field = i_instr[OFFREG_LSB +: OFFREG_W];
    wire logic [3:0]  second_hi     = i_instr[SECOND_HI_LSB +: 4];
    wire logic [3:0]  narrow_sel    = i_instr[NARROW_OFF_W +: 4];
    wire logic [5:0]  reg_mid       = i_instr[MID_LSB +: 6];
    wire logic [1:0]  offset_shift_field =
        i_instr[SHIFT_FIELD_LSB +: SHIFT_FIELD_W];
    wire logic [WIDE_OFF_W-1:0]   wide_offset_field   = i_instr[WIDE_OFF_W-1:0];
    wire logic [NARROW_OFF_W-1:0] narrow_offset_field = i_instr[NARROW_OFF_W-1:0];
    wire logic        up_bit        = i_instr[UPDOWN_BIT];
    // A base of all ones names the program counter, never a register
    wire logic        base_is_pc    = (base_reg_field == REG_PC);

    // Opcode matches; literal forms leave the up bit free
    // A form is taken only when every listed bit agrees
    wire logic m_data_wide   = ((first_hw & HW_MASK_BASE) == OP_DATA_WIDE)
                               && (second_hi == SECOND_HI_PAT);
    wire logic m_data_nr_grp = ((first_hw & HW_MASK_BASE) == OP_DATA_NARROW)
                               && (second_hi == SECOND_HI_PAT);
    wire logic m_data_narrow = m_data_nr_grp && (narrow_sel == NARROW_SEL_PAT);
    wire logic m_data_reg    = m_data_nr_grp && (reg_mid == REG_MID_PAT);
    wire logic m_data_lit    = ((first_hw & HW_MASK_U) == OP_DATA_LIT)
                               && (second_hi == SECOND_HI_PAT);
    wire logic m_code_wide   = ((first_hw & HW_MASK_BASE) == OP_CODE_WIDE)
                               && (second_hi == SECOND_HI_PAT);
    wire logic m_code_narrow = ((first_hw & HW_MASK_BASE) == OP_CODE_NARROW)
                               && (second_hi == SECOND_HI_PAT)
                               && (narrow_sel == NARROW_SEL_PAT);
    // Code literal form claims every code encoding whose base is all ones
    wire logic m_code_lit    = ((first_hw & HW_MASK_U) == OP_CODE_LIT)
                               && (second_hi == SECOND_HI_PAT);

    // Form selection; any data form with base all ones is the literal
    // Each literal form is tested before the other forms of its kind because their patterns overlap;
    // kept combinational so the hint costs one cycle only
    phd_form_t form;
    always_comb begin
        form = PHD_FORM_NONE;
        if (m_data_lit || ((m_data_wide || m_data_nr_grp) && base_is_pc)) begin
            form = PHD_FORM_DATA_LIT; // RULE9
        end else if (m_data_wide) begin
            form = PHD_FORM_DATA_WIDE;
        end else if (m_data_narrow) begin
            form = PHD_FORM_DATA_NARROW;
        end else if (m_data_reg) begin
            form = PHD_FORM_DATA_REG; // RULE13
        end else if (m_code_lit) begin
            form = PHD_FORM_CODE_LIT; // RULE15
        end else if (m_code_wide && !base_is_pc) begin
            form = PHD_FORM_CODE_WIDE; // RULE15
        end else if (m_code_narrow && !base_is_pc) begin
            form = PHD_FORM_CODE_NARROW;
        end
    end

    // Aligned program counter for literal bases
    wire logic [31:0] pc_aligned = i_pc & PC_ALIGN_MASK; // RULE4 RULE17

    // Logical shift; offset bits pushed past bit 31 are lost
    wire logic [31:0] shifted_off = i_offset_value << offset_shift_field; // RULE11

    // Per-form base, offset and direction
    // Defaults mean no hint; the address then only follows the inputs
    logic [31:0] base_sel;
    logic [31:0] extended_offset;
    logic        add_sel;
    logic        is_data;
    logic        is_code;
    always_comb begin
        base_sel        = i_base_value;
        extended_offset = 32'h00000000;
        add_sel         = 1'b1;
        is_data         = 1'b0;
        is_code         = 1'b0;
        case (form)
            PHD_FORM_DATA_WIDE: begin
                extended_offset = {{(32-WIDE_OFF_W){1'b0}}, wide_offset_field}; // RULE1
                is_data         = 1'b1;
            end
            PHD_FORM_DATA_NARROW: begin
                extended_offset = {{(32-NARROW_OFF_W){1'b0}}, narrow_offset_field};
                add_sel         = 1'b0; // RULE1
                is_data         = 1'b1;
            end
            PHD_FORM_DATA_LIT: begin
                base_sel        = pc_aligned; // RULE4
                extended_offset = {{(32-WIDE_OFF_W){1'b0}}, wide_offset_field}; // RULE3
                add_sel         = up_bit; // RULE3
                is_data         = 1'b1;
            end
            PHD_FORM_DATA_REG: begin
                extended_offset = shifted_off; // RULE12
                is_data         = 1'b1;
            end
            PHD_FORM_CODE_WIDE: begin
                extended_offset = {{(32-WIDE_OFF_W){1'b0}}, wide_offset_field}; // RULE15
                is_code         = 1'b1;
            end
            PHD_FORM_CODE_NARROW: begin
                extended_offset = {{(32-NARROW_OFF_W){1'b0}}, narrow_offset_field};
                add_sel         = 1'b0; // RULE16
                is_code         = 1'b1;
            end
            PHD_FORM_CODE_LIT: begin
                base_sel        = pc_aligned; // RULE17
                extended_offset = {{(32-WIDE_OFF_W){1'b0}}, wide_offset_field}; // RULE15
                add_sel         = up_bit; // RULE3
                is_code         = 1'b1;
            end
            default: begin
                // Unknown forms land here and issue nothing
                add_sel = 1'b1;
            end
        endcase
    end

    // Shared adder; wrap-around is the architected behaviour
    // One adder serves every form; only one form is live per cycle
    logic [31:0] calc_address;
    phd_addr_calc u_addr_calc (
        .i_base    (base_sel),
        .i_offset  (extended_offset),
        .i_add     (add_sel),
        .o_address (calc_address)
    );

    // Issue only when the condition passes; no exception path exists,
    // so a hint never faults or writes a register
    // Offset register 13 or 15 still issues; the flag lets the core react
    wire logic issue = i_instr_valid && i_cond_pass; // RULE18
    wire logic reg_unpred = (form == PHD_FORM_DATA_REG)
        && ((offset_reg_field == REG_SP) || (offset_reg_field == REG_PC)); // RULE10

    // Next hint; only the request and unpredictable bits are gated, not the address
    phd_hint_t next_hint;
    assign next_hint.data_prefetch_request = issue && is_data; // RULE2
    assign next_hint.code_prefetch_request = issue && is_code; // RULE14
    assign next_hint.unpredictable         = issue && reg_unpred;
    assign next_hint.address               = calc_address;

    // Output register; the hint is fire-and-forget, nothing waits on it
    // Downstream may drop any hint, so results never depend on it
    phd_hint_t hint;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            hint <= '0;
        end else begin
            hint <= next_hint; // RULE19
        end
    end

    // Register read addresses echoed from a flop for timing
    // They steer register reads only and carry no hint meaning
    logic [3:0] base_rf;
    logic [3:0] offset_rf;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            base_rf   <= 4'h0;
            offset_rf <= 4'h0;
        end else begin
            base_rf   <= base_reg_field;
            offset_rf <= offset_reg_field;
        end
    end

    // Every output comes straight from a flop
    assign o_base_reg_field        = base_rf;
    assign o_offset_reg_field      = offset_rf;
    assign o_data_prefetch_request = hint.data_prefetch_request;
    assign o_code_prefetch_request = hint.code_prefetch_request;
    assign o_unpredictable         = hint.unpredictable;
    assign o_hint_address          = hint.address;

endmodule : phd_preload_hint_decode

// ---- tb/phd_hint_monitor.sv ----
`timescale 1ns/1ps
module phd_hint_monitor (
    // Clock, reset and request inputs
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_instr_valid,
    input wire logic        i_cond_pass,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_pc,
    input wire logic [31:0] i_base_value,
    input wire logic [31:0] i_offset_value,
    // Hint outputs
    input wire logic        o_data_prefetch_request,
    input wire logic        o_code_prefetch_request,
    input wire logic        o_unpredictable,
    input wire logic [31:0] o_hint_address
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    logic [31:0] p_ins, p_b, p_o, p_pc;
    logic        p_go;
    // Last cycle's request, the cause of this cycle's hint
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            p_go  <= 1'b0;
            p_ins <= 32'h0000_0000;
            p_b   <= 32'h0000_0000;
            p_o   <= 32'h0000_0000;
            p_pc  <= 32'h0000_0000;
        end else begin
            p_go  <= i_instr_valid && i_cond_pass;
            p_ins <= i_instr;
            p_b   <= i_base_value;
            p_o   <= i_offset_value;
            p_pc  <= i_pc;
        end
    end
    // Form decode, done apart from the design on purpose
    wire        nf  = p_ins[19:16] != 4'hF;
    wire [31:0] pca = p_pc & 32'hFFFF_FFFC;
    wire [31:0] w12 = {20'h0, p_ins[11:0]};
    wire [31:0] n8  = {24'h0, p_ins[7:0]};
    wire        dw  = p_ins[31:20] == 12'hF89 && nf && p_ins[15:12] == 4'hF;
    wire        dn  = p_ins[31:20] == 12'hF81 && nf && p_ins[15:8] == 8'hFC;
    wire        dl  = p_ins[31:24] == 8'hF8 && p_ins[22:16] == 7'h1F && p_ins[15:12] == 4'hF;
    wire        dr  = p_ins[31:20] == 12'hF81 && nf && p_ins[15:6] == 10'h3C0;
    wire        cw  = p_ins[31:20] == 12'hF99 && nf && p_ins[15:12] == 4'hF;
    wire        cn  = p_ins[31:20] == 12'hF91 && nf && p_ins[15:8] == 8'hFC;
    wire        cl  = p_ins[31:24] == 8'hF9 && p_ins[22:16] == 7'h1F && p_ins[15:12] == 4'hF;
    wire        bad = p_ins[3:0] == 4'hD || p_ins[3:0] == 4'hF;

    // Each hint is judged one edge after the request that caused it
    no_cond_hint_a: assert property (
        (o_data_prefetch_request || o_code_prefetch_request) |-> p_go)
        else $error("hint without a passed request");
    data_add_a: assert property (
        p_go && dw |-> o_data_prefetch_request && o_hint_address == p_b + w12)
        else $error("wide data address wrong");
    data_sub_a: assert property (
        p_go && dn |-> o_data_prefetch_request && o_hint_address == p_b - n8)
        else $error("narrow data address wrong");
    literal_addr_a: assert property (
        p_go && dl |-> o_data_prefetch_request
            && o_hint_address == (p_ins[23] ? pca + w12 : pca - w12))
        else $error("literal address wrong");
    reg_offset_a: assert property (
        p_go && dr |-> o_data_prefetch_request
            && o_hint_address == p_b + (p_o << p_ins[5:4]))
        else $error("register offset address wrong");
    unpred_flag_a: assert property (
        p_go |-> o_unpredictable == (dr && bad))
        else $error("unpredictable flag wrong");
    code_add_a: assert property (
        p_go && cw |-> o_code_prefetch_request && !o_data_prefetch_request
            && o_hint_address == p_b + w12)
        else $error("wide code address wrong");
    code_sub_a: assert property (
        p_go && cn |-> o_code_prefetch_request && o_hint_address == p_b - n8)
        else $error("narrow code address wrong");
    code_lit_a: assert property (
        p_go && cl |-> o_code_prefetch_request
            && o_hint_address == (p_ins[23] ? pca + w12 : pca - w12))
        else $error("code literal address wrong");
    cover property (o_data_prefetch_request && o_unpredictable);
    cover property (p_go && cw);
    cover property (p_go && dl && !p_ins[23]);
    cover property (p_go && cl && !p_ins[23]);
endmodule : phd_hint_monitor

// ---- tb/phd_mem_model.sv ----
`timescale 1ns/1ps
// Memory system side: takes hints, only counts them
module phd_mem_model (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Hints
    input  wire logic       i_data_req,
    input  wire logic       i_code_req,
    // Counts
    output logic      [7:0] o_data_hints,
    output logic      [7:0] o_code_hints
);
    // No line fetch is modelled; nothing flows back to the core
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data_hints <= 8'h00;
            o_code_hints <= 8'h00;
        end else begin
            o_data_hints <= o_data_hints + {7'h00, i_data_req};
            o_code_hints <= o_code_hints + {7'h00, i_code_req};
        end
    end
endmodule : phd_mem_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rstn = 0, vld = 0, cnd = 1;
    logic [31:0] ins = 0, pc = 0, bv = 0, ov = 0;
    wire         dreq, creq, unp;
    wire  [31:0] addr;
    wire  [3:0]  bf, of;
    wire  [7:0]  nd, nc;
    int          miscompares = 0, n_compared = 0;
    always #10 clk = ~clk;
    phd_preload_hint_decode dut (.i_clk_sys(clk), .i_resetn(rstn), .i_instr_valid(vld),
        .i_instr(ins), .i_cond_pass(cnd), .i_pc(pc), .i_base_value(bv), .i_offset_value(ov),
        .o_base_reg_field(bf), .o_offset_reg_field(of), .o_data_prefetch_request(dreq),
        .o_code_prefetch_request(creq), .o_unpredictable(unp), .o_hint_address(addr));
    phd_mem_model u_mem (.i_clk_sys(clk), .i_resetn(rstn), .i_data_req(dreq),
        .i_code_req(creq), .o_data_hints(nd), .o_code_hints(nc));
    task automatic fail(input string m);
        miscompares++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    // One instruction per cycle, answer judged one edge later
    task automatic xfer(input logic [31:0] i, b, o, p, input logic [2:0] e, input logic [31:0] a);
        ins = i; bv = b; ov = o; pc = p; vld = 1;
        @(posedge clk); #1;
        n_compared++;
        if ({dreq, creq, unp} !== e || (e[2:1] != 0 && addr !== a) || bf !== i[19:16]
            || of !== i[3:0]) fail("hint mismatch");
    endtask : xfer
    task automatic t_data_imm;
        xfer(32'hF891_F123, 32'h0000_1000, 0, 0, 3'h4, 32'h0000_1123);
        xfer(32'hF893_FFFF, 32'h0000_0001, 0, 0, 3'h4, 32'h0000_1000);
        xfer(32'hF812_FC10, 32'h0000_0100, 0, 0, 3'h4, 32'h0000_00F0);
    endtask : t_data_imm
    task automatic t_literal;
        xfer(32'hF89F_F004, 0, 0, 32'h0000_1003, 3'h4, 32'h0000_1004);
        xfer(32'hF81F_FFFF, 0, 0, 32'h0000_2002, 3'h4, 32'h0000_1001);
        xfer(32'hF81F_F032, 0, 0, 32'h0000_0100, 3'h4, 32'h0000_00CE);
        xfer(32'hF81F_F000, 0, 0, 32'h0000_0302, 3'h4, 32'h0000_0300);
    endtask : t_literal
    task automatic t_reg;
        for (int sh = 0; sh < 4; sh++) begin
            xfer({16'hF81D, 10'h3C0, 2'(sh), 4'h2}, 32'h0000_8000, 32'h0000_0005, 0,
                 3'h4, 32'h0000_8000 + (32'h5 << sh));
        end
        xfer(32'hF811_F00D, 32'h0000_000A, 32'h0000_0001, 0, 3'h5, 32'h0000_000B);
        xfer(32'hF811_F03F, 32'h0000_0000, 32'h0000_0001, 0, 3'h5, 32'h0000_0008);
    endtask : t_reg
    task automatic t_code;
        xfer(32'hF991_F010, 32'h0000_0200, 0, 0, 3'h2, 32'h0000_0210);
        xfer(32'hF912_FC08, 32'h0000_0200, 0, 0, 3'h2, 32'h0000_01F8);
        xfer(32'hF99F_F010, 0, 0, 32'h0000_0203, 3'h2, 32'h0000_0210);
        xfer(32'hF91F_F010, 0, 0, 32'h0000_0202, 3'h2, 32'h0000_01F0);
    endtask : t_code
    task automatic t_cond;
        xfer(32'hF810_FE00, 0, 0, 0, 3'h0, 0);
        cnd = 0;
        xfer(32'hF891_F123, 32'h0000_1000, 0, 0, 3'h0, 0);
        cnd = 1;
        vld = 0;
        @(posedge clk); #1;
        n_compared++;
        if (nd !== 8'd13 || nc !== 8'd4) fail("hint count");
        if ({dreq, creq, unp} !== 3'h0) fail("hint while not valid");
    endtask : t_cond
    task automatic tally_and_finish;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Run takes about forty cycles; a thousand cycles means a hang
    initial begin
        #20000;
        fail("timeout");
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 rstn = 1;
        t_data_imm();
        t_literal();
        t_reg();
        t_code();
        t_cond();
        tally_and_finish();
    end
endmodule : tb
bind phd_preload_hint_decode phd_hint_monitor u_mon (
    .i_clk_sys               (i_clk_sys),
    .i_resetn                (i_resetn),
    .i_instr_valid           (i_instr_valid),
    .i_cond_pass             (i_cond_pass),
    .i_instr                 (i_instr),
    .i_pc                    (i_pc),
    .i_base_value            (i_base_value),
    .i_offset_value          (i_offset_value),
    .o_data_prefetch_request (o_data_prefetch_request),
    .o_code_prefetch_request (o_code_prefetch_request),
    .o_unpredictable         (o_unpredictable),
    .o_hint_address          (o_hint_address)
);
